//--- src/ist_io_shutdown.sv
// io shutdown supervisor of one controller: timers, autotest schedule, registers
module ist_io_shutdown import ist_pkg::*; #(
  parameter int unsigned NGRP = 4,
  parameter int unsigned GW = 16,
  parameter logic [1:0] MY_ID = 2'h0,
  parameter logic [NGRP-1:0] GRP_IS_OUT = 4'b0011,
  parameter logic [NGRP-1:0] GRP_SYNC_AT = 4'b0100,
  parameter logic [NGRP*GW-1:0] IN_DEFAULT = '0,
  parameter logic [7:0] AT_INTERVAL_CFG = AT_INTERVAL_DEF,
  parameter int unsigned CYC_SEC = CYC_PER_SEC,
  parameter int unsigned SEC_HR = SEC_PER_HOUR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic at_master,
  output logic at_req,
  input wire logic at_done,
  input wire ist_fault_s [NGRP-1:0] at_fault,
  output logic master_pass,
  output logic [1:0] next_master,
  output logic fault_contact,
  output logic shutdown_pending_flag,
  output logic [NGRP-1:0] grp_shutdown,
  input wire logic [NGRP*GW-1:0] out_data_in,
  output logic [NGRP*GW-1:0] out_data,
  input wire logic [NGRP*GW-1:0] in_data_in,
  output logic [NGRP*GW-1:0] in_data,
  output logic io_fault_reset_pulse,
  output logic forced_logon_pulse
);
  localparam logic [1:0] LAST_ID = 2'h2;
  localparam logic [1:0] NEXT_ID = (MY_ID == LAST_ID) ? 2'h0 : MY_ID + 2'h1;

  logic hour_tick;
  logic [NGRP-1:0] qual, raw_fault, running, shut, sd_apply;
  ist_evt_s [NGRP-1:0] grp_evt;
  ist_evt_s evt_any;

  logic cancel_r, cancel_nxt;
  logic [7:0] interval_r, interval_nxt;
  logic [7:0] at_cnt_r, at_cnt_nxt;
  logic at_busy_r, at_busy_nxt;
  logic at_req_nxt;
  logic [NGRP-1:0] fault_tbl_r, fault_tbl_nxt;
  ist_evt_s evt_stat_r, evt_stat_nxt;
  ist_evt_s evt_mask_r, evt_mask_nxt;
  logic [31:0] rdata_nxt;
  logic pass_nxt, fres_nxt, logon_nxt;
  logic wr_ctrl, manual_go, sched_go, launch;
  logic [NGRP*GW-1:0] out_nxt, in_nxt;

  ist_hour_tick #(
    .CYC_SEC(CYC_SEC),
    .SEC_HR(SEC_HR)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .hour_tick(hour_tick)
  );

  // fault qualification per group type
  always_comb begin
    for (int g = 0; g < NGRP; g++) begin
      raw_fault[g] = at_fault[g].comm_loss | at_fault[g].q16_fail | at_fault[g].out_stuck;
      if (GRP_IS_OUT[g]) begin
        qual[g] = at_fault[g].comm_loss | at_fault[g].out_stuck;
      end else if (GRP_SYNC_AT[g]) begin
        qual[g] = at_fault[g].comm_loss | at_fault[g].q16_fail;
      end else begin
        qual[g] = 1'b0;
      end
    end
  end

  // one independent timer per group
  for (genvar g = 0; g < NGRP; g++) begin : g_tmr
    ist_group_timer u_tmr (
      .clk(clk),
      .rst_n(rst_n),
      .hour_tick(hour_tick),
      .at_done(at_done),
      .qual(qual[g]),
      .running(running[g]),
      .shut(shut[g]),
      .evt(grp_evt[g])
    );
  end

  always_comb begin
    evt_any = '0;
    for (int g = 0; g < NGRP; g++) begin
      evt_any = evt_any | grp_evt[g];
    end
  end

  assign sd_apply = cancel_r ? '0 : shut;
  assign shutdown_pending_flag = |running;
  assign fault_contact = |fault_tbl_r;
  assign irq = |(evt_stat_r & evt_mask_r);

  // control, schedule and register next values
  always_comb begin
    wr_ctrl = wr && (addr == OFS_CTRL);
    manual_go = wr_ctrl && wdata[CTRL_MANUAL_AT];
    sched_go = hour_tick && at_master && (at_cnt_r + 8'h1 >= interval_r);
    launch = (manual_go || sched_go) && !at_busy_r;

    cancel_nxt = wr_ctrl ? wdata[CTRL_CANCEL] : cancel_r;
    interval_nxt = (wr && addr == OFS_AT_INTERVAL) ? wdata[7:0] : interval_r;

    at_cnt_nxt = at_cnt_r;
    if (launch) begin
      at_cnt_nxt = '0;
    end else if (hour_tick && at_master) begin
      at_cnt_nxt = at_cnt_r + 8'h1;
    end
    at_req_nxt = launch;
    at_busy_nxt = at_busy_r;
    if (launch) begin
      at_busy_nxt = 1'b1;
    end else if (at_done) begin
      at_busy_nxt = 1'b0;
    end

    pass_nxt = at_done && at_master && (|qual);
    fres_nxt = wr_ctrl && wdata[CTRL_FAULT_RESET];
    logon_nxt = wr_ctrl && wdata[CTRL_FORCED_LOGON];

    // new faults win over a reset in the same cycle
    fault_tbl_nxt = fres_nxt ? '0 : fault_tbl_r;
    if (at_done) begin
      fault_tbl_nxt = fault_tbl_nxt | raw_fault;
    end

    evt_mask_nxt = (wr && addr == OFS_EVT_MASK) ? ist_evt_s'(wdata[3:0]) : evt_mask_r;
    evt_stat_nxt = (rd && addr == OFS_EVT_STAT) ? ist_evt_s'(4'h0) : evt_stat_r;
    evt_stat_nxt = evt_stat_nxt | evt_any;

    rdata_nxt = RD_UNMAPPED;
    if (rd) begin
      unique case (addr)
        OFS_CTRL: rdata_nxt[CTRL_CANCEL] = cancel_r;
        OFS_STATUS: begin
          rdata_nxt[ST_PENDING] = shutdown_pending_flag;
          rdata_nxt[ST_FAULT_CONTACT] = fault_contact;
          rdata_nxt[ST_MASTER] = at_master;
          rdata_nxt[ST_AT_BUSY] = at_busy_r;
        end
        OFS_AT_INTERVAL: rdata_nxt[7:0] = interval_r;
        OFS_FAULT_TBL: rdata_nxt[NGRP-1:0] = fault_tbl_r;
        OFS_PENDING: rdata_nxt[NGRP-1:0] = running;
        OFS_SHUTDOWN: rdata_nxt[NGRP-1:0] = sd_apply;
        OFS_EVT_STAT: rdata_nxt[3:0] = evt_stat_r;
        OFS_EVT_MASK: rdata_nxt[3:0] = evt_mask_r;
        default: rdata_nxt = RD_UNMAPPED;
      endcase
    end
  end

  // safe state substitution of this controller's io copy
  always_comb begin
    out_nxt = out_data_in;
    in_nxt = in_data_in;
    for (int g = 0; g < NGRP; g++) begin
      if (sd_apply[g]) begin
        out_nxt[g*GW +: GW] = '0;
        in_nxt[g*GW +: GW] = IN_DEFAULT[g*GW +: GW];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cancel_r <= 1'b0;
      interval_r <= AT_INTERVAL_CFG;
      at_cnt_r <= '0;
      at_busy_r <= 1'b0;
      at_req <= 1'b0;
      fault_tbl_r <= '0;
      evt_stat_r <= '0;
      evt_mask_r <= EVT_MASK_RST;
      rdata <= '0;
      master_pass <= 1'b0;
      io_fault_reset_pulse <= 1'b0;
      forced_logon_pulse <= 1'b0;
      grp_shutdown <= '0;
      out_data <= '0;
      in_data <= '0;
    end else begin
      cancel_r <= cancel_nxt;
      interval_r <= interval_nxt;
      at_cnt_r <= at_cnt_nxt;
      at_busy_r <= at_busy_nxt;
      at_req <= at_req_nxt;
      fault_tbl_r <= fault_tbl_nxt;
      evt_stat_r <= evt_stat_nxt;
      evt_mask_r <= evt_mask_nxt;
      rdata <= rdata_nxt;
      master_pass <= pass_nxt;
      io_fault_reset_pulse <= fres_nxt;
      forced_logon_pulse <= logon_nxt;
      grp_shutdown <= sd_apply;
      out_data <= out_nxt;
      in_data <= in_nxt;
    end
  end

  assign next_master = NEXT_ID;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_cancel_blocks_sd: assert property (cancel_r && $past(cancel_r) |-> grp_shutdown == '0)
    else $error("shutdown applied while cancel is set");
  a_outputs_forced_off: assert property (sd_apply[0] |=> out_data[GW-1:0] == '0)
    else $error("shut group outputs not driven off");
  a_inputs_to_default: assert property (sd_apply[NGRP-1] |=> in_data[NGRP*GW-1 -: GW] == IN_DEFAULT[NGRP*GW-1 -: GW])
    else $error("shut group inputs not replaced by default");
  a_async_never_runs: assert property (!GRP_IS_OUT[3] && !GRP_SYNC_AT[3] |-> !running[3] && !shut[3])
    else $error("asynchronous input group started a timer");
  a_pending_on_start: assert property (at_done && |qual && !(|running) && !(|shut) |=> shutdown_pending_flag)
    else $error("pending flag not set after timer start");
  a_fault_logged: assert property (at_done && |raw_fault |=> fault_contact)
    else $error("fault not logged");
  a_manual_start: assert property (manual_go && !at_busy_r |=> at_req ##1 !at_req)
    else $error("manual autotest did not start");
  a_master_passes: assert property (at_done && at_master && |qual |=> master_pass && next_master != MY_ID)
    else $error("autotest master not passed on");
  a_fault_reset: assert property (fres_nxt && !at_done |=> fault_tbl_r == '0 && io_fault_reset_pulse)
    else $error("fault reset did not clear fault table");
  a_logon_pulse: assert property (logon_nxt |=> forced_logon_pulse ##1 !forced_logon_pulse || logon_nxt)
    else $error("forced logon pulse missing");
  a_interval_write: assert property (wr && addr == OFS_AT_INTERVAL |=> interval_r == $past(wdata[7:0]))
    else $error("autotest interval not written");

  c_timer_started: cover property (at_done && |qual ##1 shutdown_pending_flag);
  c_shutdown_done: cover property (|sd_apply);
  c_auto_cancel: cover property (|evt_any.cancel);
  c_irq_raised: cover property ($rose(irq));
endmodule : ist_io_shutdown

//--- src/ist_pkg.sv
// shared constants, types and register map of the io shutdown timer
package ist_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CYC_PER_SEC = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int unsigned SEC_PER_HOUR = 3600;
  localparam logic [3:0] SD_HOURS = 4'h8;
  localparam logic [3:0] WARN_HOURS = 4'h1;
  localparam logic [7:0] AT_INTERVAL_DEF = 8'h08;

  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_AT_INTERVAL = 4'h2;
  localparam logic [3:0] OFS_FAULT_TBL = 4'h3;
  localparam logic [3:0] OFS_PENDING = 4'h4;
  localparam logic [3:0] OFS_SHUTDOWN = 4'h5;
  localparam logic [3:0] OFS_EVT_STAT = 4'h6;
  localparam logic [3:0] OFS_EVT_MASK = 4'h7;

  localparam int unsigned CTRL_CANCEL = 0;
  localparam int unsigned CTRL_MANUAL_AT = 1;
  localparam int unsigned CTRL_FAULT_RESET = 2;
  localparam int unsigned CTRL_FORCED_LOGON = 3;

  localparam int unsigned ST_PENDING = 0;
  localparam int unsigned ST_FAULT_CONTACT = 1;
  localparam int unsigned ST_MASTER = 2;
  localparam int unsigned ST_AT_BUSY = 3;

  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  localparam logic [3:0] EVT_MASK_RST = 4'h0;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'b00,
    TMR_RUN = 2'b01,
    TMR_SHUT = 2'b11
  } ist_tmr_e;

  typedef struct packed {
    logic comm_loss;
    logic q16_fail;
    logic out_stuck;
  } ist_fault_s;

  typedef struct packed {
    logic cancel;
    logic shut;
    logic warn1;
    logic warn8;
  } ist_evt_s;
endpackage : ist_pkg

//--- src/ist_hour_tick.sv
// hour tick prescaler
module ist_hour_tick import ist_pkg::*; #(
  parameter int unsigned CYC_SEC = CYC_PER_SEC,
  parameter int unsigned SEC_HR = SEC_PER_HOUR
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic hour_tick
);
  logic [31:0] cyc_r, cyc_nxt;
  logic [15:0] sec_r, sec_nxt;
  logic tick_nxt;

  always_comb begin
    cyc_nxt = cyc_r + 32'h1;
    sec_nxt = sec_r;
    tick_nxt = 1'b0;
    if (cyc_r == 32'(CYC_SEC - 1)) begin
      cyc_nxt = '0;
      if (sec_r == 16'(SEC_HR - 1)) begin
        sec_nxt = '0;
        tick_nxt = 1'b1;
      end else begin
        sec_nxt = sec_r + 16'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r <= '0;
      sec_r <= '0;
      hour_tick <= 1'b0;
    end else begin
      cyc_r <= cyc_nxt;
      sec_r <= sec_nxt;
      hour_tick <= tick_nxt;
    end
  end
endmodule : ist_hour_tick

//--- src/ist_group_timer.sv
// shutdown timer of one io group
module ist_group_timer import ist_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hour_tick,
  input wire logic at_done,
  input wire logic qual,
  output logic running,
  output logic shut,
  output ist_evt_s evt
);
  ist_tmr_e st_r, st_nxt;
  logic [3:0] hrs_r, hrs_nxt;
  ist_evt_s evt_nxt;

  always_comb begin
    st_nxt = st_r;
    hrs_nxt = hrs_r;
    evt_nxt = '0;
    unique case (st_r)
      TMR_IDLE: begin
        if (at_done && qual) begin
          st_nxt = TMR_RUN;
          hrs_nxt = '0;
          evt_nxt.warn8 = 1'b1;
        end
      end
      TMR_RUN: begin
        if (at_done && !qual) begin
          st_nxt = TMR_IDLE;
          evt_nxt.cancel = 1'b1;
        end else if (hour_tick) begin
          hrs_nxt = hrs_r + 4'h1;
          if (hrs_nxt == SD_HOURS - WARN_HOURS) begin
            evt_nxt.warn1 = 1'b1;
          end
          if (hrs_nxt == SD_HOURS) begin
            st_nxt = TMR_SHUT;
            evt_nxt.shut = 1'b1;
          end
        end
      end
      TMR_SHUT: begin
        if (at_done && !qual) begin
          st_nxt = TMR_IDLE;
        end
      end
      default: st_nxt = TMR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= TMR_IDLE;
      hrs_r <= '0;
      evt <= '0;
    end else begin
      st_r <= st_nxt;
      hrs_r <= hrs_nxt;
      evt <= evt_nxt;
    end
  end

  assign running = (st_r == TMR_RUN);
  assign shut = (st_r == TMR_SHUT);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_auto_cancel: assert property (running && at_done && !qual |=> !running && !shut && evt.cancel)
    else $error("fault-free autotest did not cancel the timer");
  a_shut_holds: assert property (shut && !(at_done && !qual) |=> shut)
    else $error("shutdown released without a fault-free autotest");
  a_expiry_hour: assert property (running && hour_tick && !at_done && hrs_r == SD_HOURS - 4'h1 |=> shut && evt.shut)
    else $error("timer did not expire at the full period");
  a_warn_one_hour: assert property (evt.warn1 |-> running && hrs_r == SD_HOURS - WARN_HOURS)
    else $error("one-hour warning at wrong time");
endmodule : ist_group_timer

//--- verification/ist_at_engine.sv
// autotest engine and remote io block model on the far side of the supervisor
module ist_at_engine import ist_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic at_req,
  input wire ist_fault_s [3:0] fault_set,
  input wire logic [3:0] dly,
  output logic at_done,
  output ist_fault_s [3:0] at_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  logic busy_r;
  logic [11:0] noise_r;
  // fault lines only meaningful in the done cycle
  assign at_fault = at_done ? fault_set : noise_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      at_done <= 1'b0;
      noise_r <= 12'ha53;
    end else begin
      noise_r <= {noise_r[10:0], ~noise_r[11]};
      at_done <= busy_r && cnt_r == 4'h0;
      if (at_req) begin
        busy_r <= 1'b1;
        cnt_r <= dly;
      end else if (busy_r) begin
        busy_r <= cnt_r != 4'h0;
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule : ist_at_engine

//--- verification/tb_ist_io_shutdown.sv
// self-checking bench of the io shutdown supervisor
module tb_ist_io_shutdown import ist_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] IN_DEF = 64'h5a5a_0f0f_3c3c_a5a5;
  logic clk, rst_n, wr, rd, irq, at_master, at_req, at_done, master_pass, fc, pend, iorp, flp, rd_q;
  logic [3:0] addr, grp_sd, dly;
  logic [31:0] wdata, rdata;
  logic [1:0] next_m;
  logic [63:0] odi, odo, idi, ido;
  ist_fault_s [3:0] at_fault, fset;
  logic [63:0] exp_q[$];
  int n_errors, comparisons, seed, cyc, n_req, n_pass, n_rst, n_log;

  ist_io_shutdown #(.IN_DEFAULT(IN_DEF), .CYC_SEC(4), .SEC_HR(2)) i_dut (
    .clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .irq, .at_master, .at_req, .at_done, .at_fault,
    .master_pass, .next_master(next_m), .fault_contact(fc), .shutdown_pending_flag(pend),
    .grp_shutdown(grp_sd), .out_data_in(odi), .out_data(odo), .in_data_in(idi), .in_data(ido),
    .io_fault_reset_pulse(iorp), .forced_logon_pulse(flp));
  ist_at_engine i_eng (.clk, .rst_n, .at_req, .fault_set(fset), .dly, .at_done, .at_fault);

  task automatic ck(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : ck

  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // expected word queued, monitor compares it in the answer cycle
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back({32'h0, e});
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic autotest(input logic [11:0] f);
    int k;
    @(posedge clk);
    fset <= f;
    wr_reg(OFS_CTRL, 32'h2);
    k = 0;
    while (at_done !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    ck(at_done, 1'b1);
    @(negedge clk);
  endtask : autotest

  task automatic chk_data(input logic [3:0] sd);
    logic [63:0] eo, ei;
    @(posedge clk);
    odi <= {$random(seed), $random(seed)};
    idi <= {$random(seed), $random(seed)};
    repeat (2) @(posedge clk);
    @(negedge clk);
    eo = odi;
    ei = idi;
    for (int g = 0; g < 4; g++) begin
      if (sd[g]) begin
        eo[g*16+:16] = 16'h0;
        ei[g*16+:16] = IN_DEF[g*16+:16];
      end
    end
    ck(odo, eo);
    ck(ido, ei);
  endtask : chk_data

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    rd_q <= rd;
    cyc <= cyc + 1;
  end

  always @(negedge clk) begin
    if (at_req === 1'b1) n_req++;
    if (master_pass === 1'b1) n_pass++;
    if (iorp === 1'b1) n_rst++;
    if (flp === 1'b1) n_log++;
    if (rd_q === 1'b1) ck(rdata, exp_q.pop_front());
  end

  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    test_done();
  end

  initial begin
    int t0;
    seed = 32'hb57b;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    rd_q = 1'b0;
    at_master = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    fset = 12'h0;
    dly = 4'h3;
    odi = 64'h0;
    idi = 64'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(OFS_AT_INTERVAL, 32'h8);
    wr_reg(OFS_AT_INTERVAL, 32'h3);
    rd_reg(OFS_AT_INTERVAL, 32'h3);
    rd_reg(4'hf, RD_UNMAPPED);
    wr_reg(OFS_EVT_MASK, 32'h4);
    at_master <= 1'b1;
    // g3 async comm+q16, g2 sync q16, g1 clean, g0 out comm loss
    autotest(12'b110_010_000_100);
    ck({fc, pend, irq, next_m}, 5'b11001);
    @(posedge clk);
    at_master <= 1'b0;
    t0 = cyc;
    rd_reg(OFS_PENDING, 32'h5);
    rd_reg(OFS_FAULT_TBL, 32'hd);
    rd_reg(OFS_STATUS, 32'h3);
    rd_reg(OFS_EVT_STAT, 32'h1);
    rd_reg(OFS_EVT_STAT, 32'h0);
    wr_reg(OFS_CTRL, 32'h1);
    rd_reg(OFS_CTRL, 32'h1);
    do @(negedge clk); while (irq !== 1'b1 && cyc - t0 < 90);
    ck(cyc - t0 inside {[50:72]}, 1'b1);
    repeat (3) @(negedge clk);
    ck(grp_sd, 4'h0);
    chk_data(4'h0);
    wr_reg(OFS_CTRL, 32'h0);
    repeat (2) @(negedge clk);
    ck(grp_sd, 4'h5);
    chk_data(4'h5);
    rd_reg(OFS_SHUTDOWN, 32'h5);
    rd_reg(OFS_EVT_STAT, 32'h6);
    @(negedge clk);
    ck(irq, 1'b0);
    autotest(12'h0);
    // applied shutdown is registered one cycle behind the timer state
    @(negedge clk);
    ck({grp_sd, pend}, 5'h0);
    chk_data(4'h0);
    autotest(12'b000_000_001_000);
    rd_reg(OFS_PENDING, 32'h2);
    autotest(12'h0);
    ck(pend, 1'b0);
    rd_reg(OFS_EVT_STAT, 32'h9);
    rd_reg(OFS_FAULT_TBL, 32'hf);
    wr_reg(OFS_CTRL, 32'h4);
    rd_reg(OFS_FAULT_TBL, 32'h0);
    wr_reg(OFS_CTRL, 32'h8);
    rd_reg(OFS_CTRL, 32'h0);
    repeat (3) @(negedge clk);
    ck(fc, 1'b0);
    ck(n_rst, 1);
    ck(n_log, 1);
    ck(n_req, 4);
    ck(n_pass, 1);
    test_done();
  end
endmodule : tb_ist_io_shutdown
